/* asr_pkg.sv */
package asr_pkg;
  // geometry of the memory outside
  localparam int ADDR_W = 17;  // address lines
  localparam int DATA_W = 8;   // data lines
  localparam int WORDS  = 131072;
  // clock figures
  localparam int CLK_PERIOD_NS = 25;
  // time in which the device must stay deselected after power returns
  localparam int REC_PD_MS     = 5;
  localparam int REC_PD_CYCLES = (REC_PD_MS * 1000000) / CLK_PERIOD_NS;
  // least deselect lead before power drops (zero, one cycle kept anyway)
  localparam int SU_PD_NS      = 0;
  // timer loads in clock cycles for one access; each phase lasts one cycle more
  localparam int SETUP_CYC     = 1;  // address stable before strobe
  localparam int STROBE_CYC    = 4;  // strobe low time, 5 cycles, 125 ns
  localparam int ACCESS_CYC    = 6;  // read access, gate low 7 cycles, 175 ns
  localparam int CNT_W         = 24;
  localparam logic [CNT_W-1:0] CNT_ZERO = 24'h00_0000;
  localparam logic [DATA_W-1:0] DATA_ZERO = 8'h00;
  localparam logic [ADDR_W-1:0] ADDR_ZERO = 17'h0_0000;
  // controller states
  typedef enum logic [2:0] {
    ASR_RECOVER = 3'b000,
    ASR_IDLE    = 3'b001,
    ASR_SETUP   = 3'b010,
    ASR_WSTROBE = 3'b011,
    ASR_WEND    = 3'b100,
    ASR_READ    = 3'b101,
    ASR_DOWN    = 3'b110
  } asr_state_t;
endpackage

/* asr_timer.sv */
// down counter for phase lengths
module asr_timer
  import asr_pkg::*;
(
  // clock and control
  input  wire logic             sys_clk,
  input  wire logic             rst_n,
  input  wire logic             clk_en,
  // load a count, run to zero
  input  wire logic             load,
  input  wire logic [CNT_W-1:0] load_val,
  output      logic             done
);
  // state of the counter
  typedef struct packed {
    logic [CNT_W-1:0] cnt;
  } asr_tmr_t;
  asr_tmr_t st_reg;
  asr_tmr_t st_next;

  // next count
  always_comb
  begin
    st_next = st_reg;
    if (load)
    begin
      st_next.cnt = load_val;
    end
    else if (st_reg.cnt != CNT_ZERO)
    begin
      st_next.cnt = st_reg.cnt - 24'h00_0001;
    end
  end

  // register with synchronous reset
  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
    begin
      st_reg <= '0;
    end
    else if (clk_en)
    begin
      st_reg <= st_next;
    end
  end

  // zero means phase over
  assign done = (st_reg.cnt == CNT_ZERO);
endmodule

/* asr_ctrl.sv */
module asr_ctrl
  import asr_pkg::*;
#(
  parameter int REC_CYCLES = REC_PD_CYCLES  // power-up recovery count
)
(
  // clock, reset, enable
  input  wire logic              sys_clk,
  input  wire logic              rst_n,
  input  wire logic              clk_en,
  // user request side
  input  wire logic              req_valid,
  input  wire logic              req_write,
  input  wire logic [ADDR_W-1:0] req_addr,
  input  wire logic [DATA_W-1:0] req_wdata,
  output      logic              req_ready,
  output      logic              rd_valid,
  output      logic [DATA_W-1:0] rd_data,
  // power sequencing
  input  wire logic              pwr_down_req,
  input  wire logic              pwr_good,
  output      logic              pwr_off_ok,
  // memory pins
  output      logic [ADDR_W-1:0] mem_addr,
  output      logic              select_low_primary_n,
  output      logic              select_high_secondary,
  output      logic              store_n,
  output      logic              out_gate_n,
  input  wire logic [DATA_W-1:0] dq_in,
  output      logic [DATA_W-1:0] dq_out,
  output      logic              dq_oe_n
);
  // all state in one record
  typedef struct packed {
    asr_state_t        state;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
    logic [DATA_W-1:0] rdata;
    logic              sel_n;
    logic              sel_h;
    logic              we_n;
    logic              oe_n;
    logic              dq_oe_n;
    logic              write;
    logic              rvalid;
    logic              ready;
    logic              off_ok;
    logic              armed;    // recovery count started since reset
  } asr_ctl_t;
  asr_ctl_t st_reg;
  asr_ctl_t st_next;

  // timer handshake
  logic             tmr_load;   // start a phase
  logic [CNT_W-1:0] tmr_val;    // phase length
  logic             tmr_done;   // phase over

  asr_timer u_timer (
    .sys_clk  (sys_clk),
    .rst_n    (rst_n),
    .clk_en   (clk_en),
    .load     (tmr_load),
    .load_val (tmr_val),
    .done     (tmr_done)
  );

  // next-state logic
  always_comb
  begin
    st_next        = st_reg;
    tmr_load       = 1'b0;
    tmr_val        = CNT_ZERO;
    st_next.rvalid = 1'b0;
    unique case (st_reg.state)
      // after reset or power return: stay deselected
      ASR_RECOVER:
      begin
        st_next.sel_n = 1'b1;
        st_next.sel_h = 1'b0;
        if (!pwr_good || !st_reg.armed)
        begin
          // timer idles at zero after reset, so start the count here
          st_next.armed = 1'b1;
          tmr_load      = 1'b1;
          tmr_val       = CNT_W'(REC_CYCLES);
        end
        else if (tmr_done && !pwr_down_req)
        begin
          st_next.state = ASR_IDLE;
          st_next.ready = 1'b1;
        end
      end
      // waiting for a request
      ASR_IDLE:
      begin
        if (pwr_down_req || !pwr_good)
        begin
          // deselect before the supply may drop
          st_next.sel_n  = 1'b1;
          st_next.sel_h  = 1'b0;
          st_next.ready  = 1'b0;
          st_next.state  = ASR_DOWN;
        end
        else if (req_valid)
        begin
          // address set while still deselected
          st_next.addr  = req_addr;
          st_next.wdata = req_wdata;
          st_next.write = req_write;
          st_next.ready = 1'b0;
          st_next.state = ASR_SETUP;
          tmr_load      = 1'b1;
          tmr_val       = CNT_W'(SETUP_CYC);
        end
      end
      // select with address stable
      ASR_SETUP:
      begin
        if (tmr_done)
        begin
          st_next.sel_n = 1'b0;
          st_next.sel_h = 1'b1;
          tmr_load      = 1'b1;
          if (st_reg.write)
          begin
            // strobe falls with select, gate high: outputs stay off
            st_next.we_n    = 1'b0;
            st_next.oe_n    = 1'b1;
            st_next.dq_oe_n = 1'b0;
            tmr_val         = CNT_W'(STROBE_CYC);
            st_next.state   = ASR_WSTROBE;
          end
          else
          begin
            // read: strobe high, gate low, our drivers off
            st_next.we_n    = 1'b1;
            st_next.oe_n    = 1'b0;
            st_next.dq_oe_n = 1'b1;
            tmr_val         = CNT_W'(ACCESS_CYC);
            st_next.state   = ASR_READ;
          end
        end
      end
      // write strobe low, data held
      ASR_WSTROBE:
      begin
        if (tmr_done)
        begin
          // strobe rises first: data latched here
          st_next.we_n  = 1'b1;
          st_next.state = ASR_WEND;
        end
      end
      // deselect and release data on the same edge, address held
      ASR_WEND:
      begin
        st_next.sel_n   = 1'b1;
        st_next.sel_h   = 1'b0;
        st_next.dq_oe_n = 1'b1;
        st_next.ready   = 1'b1;
        st_next.state   = ASR_IDLE;
      end
      // read access
      ASR_READ:
      begin
        if (tmr_done)
        begin
          st_next.rdata  = dq_in;
          st_next.rvalid = 1'b1;
          st_next.oe_n   = 1'b1;
          st_next.sel_n  = 1'b1;
          st_next.sel_h  = 1'b0;
          st_next.ready  = 1'b1;
          st_next.state  = ASR_IDLE;
        end
      end
      // deselected, supply may be cut
      ASR_DOWN:
      begin
        st_next.off_ok = 1'b1;
        if (!pwr_down_req && pwr_good)
        begin
          st_next.off_ok = 1'b0;
          st_next.state  = ASR_RECOVER;
          tmr_load       = 1'b1;
          tmr_val        = CNT_W'(REC_CYCLES);
        end
      end
      default:
      begin
        st_next.state = ASR_RECOVER;
      end
    endcase
  end

  // state register
  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
    begin
      st_reg         <= '0;
      st_reg.state   <= ASR_RECOVER;
      st_reg.addr    <= ADDR_ZERO;
      st_reg.sel_n   <= 1'b1;
      st_reg.we_n    <= 1'b1;
      st_reg.oe_n    <= 1'b1;
      st_reg.dq_oe_n <= 1'b1;
    end
    else if (clk_en)
    begin
      st_reg <= st_next;
    end
  end

  // outputs straight from the record
  assign mem_addr              = st_reg.addr;
  assign select_low_primary_n  = st_reg.sel_n;
  assign select_high_secondary = st_reg.sel_h;
  assign store_n               = st_reg.we_n;
  assign out_gate_n            = st_reg.oe_n;
  assign dq_out                = st_reg.wdata;
  assign dq_oe_n               = st_reg.dq_oe_n;
  assign req_ready             = st_reg.ready;
  assign rd_valid              = st_reg.rvalid;
  assign rd_data               = st_reg.rdata;
  assign pwr_off_ok            = st_reg.off_ok;

  // checks
  logic sel_act;
  assign sel_act = !st_reg.sel_n && st_reg.sel_h;

  AST_NO_WR_DESEL: assert property (@(posedge sys_clk) disable iff (!rst_n)
    !sel_act |-> st_reg.we_n)
    else $error("strobe low while deselected");
  AST_WR_GATE_HIGH: assert property (@(posedge sys_clk) disable iff (!rst_n)
    !st_reg.we_n |-> st_reg.oe_n && !st_reg.dq_oe_n)
    else $error("gate low during write");
  AST_NO_CONTENTION: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (!st_reg.oe_n && sel_act) |-> st_reg.dq_oe_n)
    else $error("bus driven during read");
  AST_ADDR_HOLD: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (sel_act && $past(sel_act) && clk_en) |-> $stable(st_reg.addr))
    else $error("address moved while selected");
  AST_STROBE_FIRST: assert property (@(posedge sys_clk) disable iff (!rst_n)
    $rose(st_reg.we_n) && clk_en |-> sel_act)
    else $error("select left before strobe");
  AST_WR_LEN: assert property (@(posedge sys_clk) disable iff (!rst_n)
    $fell(st_reg.we_n) |-> !st_reg.we_n [*4])
    else $error("write strobe too short");
  AST_DOWN_DESEL: assert property (@(posedge sys_clk) disable iff (!rst_n)
    st_reg.off_ok |-> st_reg.sel_n && !st_reg.sel_h)
    else $error("power off while selected");
  AST_RECOVER: assert property (@(posedge sys_clk) disable iff (!rst_n)
    st_reg.state == ASR_RECOVER |-> !sel_act && !st_reg.ready)
    else $error("selected during recovery");
  AST_READ_MODE: assert property (@(posedge sys_clk) disable iff (!rst_n)
    st_reg.state == ASR_READ |-> st_reg.we_n && !st_reg.oe_n && sel_act)
    else $error("bad read pins");
  COV_WRITE: cover property (@(posedge sys_clk) st_reg.state == ASR_WEND);
  COV_READ:  cover property (@(posedge sys_clk) rd_valid);
  COV_DOWN:  cover property (@(posedge sys_clk) st_reg.off_ok);
endmodule

/* asr_sram_model.sv */
// memory device on the far side of the controller
module asr_sram_model
  import asr_pkg::*;
(
  // pins from the controller
  input  wire logic [ADDR_W-1:0] mem_addr,
  input  wire logic              select_low_primary_n,
  input  wire logic              select_high_secondary,
  input  wire logic              store_n,
  input  wire logic              out_gate_n,
  input  wire logic [DATA_W-1:0] dq_out,
  input  wire logic              dq_oe_n,
  // resolved bus, sticky faults
  output      logic [DATA_W-1:0] dq_in,
  output      logic [1:0]        fault
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [DATA_W-1:0] cells [WORDS];     // byte array
  logic              sel;               // both selects active
  logic              wr_act;            // write overlap
  logic              rd_act;            // device drives bus
  logic [DATA_W-1:0] drv;               // whoever drives
  logic [DATA_W-1:0] held = DATA_ZERO;  // last driven value
  assign sel    = !select_low_primary_n && select_high_secondary;
  assign wr_act = sel && !store_n;
  assign rd_act = sel && store_n && !out_gate_n;
  assign drv    = !dq_oe_n ? dq_out : cells[mem_addr];
  // undriven bus shows the inverse, no keeper on it
  assign dq_in  = (!dq_oe_n || rd_act) ? drv : ~held;
  initial fault = 2'h0;
  // remember driven level
  always @(drv, dq_oe_n, rd_act) if (!dq_oe_n || rd_act) held = drv;
  // latch on first qualifier leaving
  always @(negedge wr_act) cells[mem_addr] = dq_in;
  // both parties driving
  always @(dq_oe_n, rd_act) if (!dq_oe_n && rd_act) fault[0] = 1'b1;
  // address moved inside write
  always @(mem_addr) if (wr_act) fault[1] = 1'b1;
endmodule

/* tb_top.sv */
`define CHK(a, e) \
  begin \
    checks++; \
    if ((a) !== (e)) \
    begin \
      fails++; \
      $display("unexpected %0t: %h/%h", $time, a, e); \
    end \
  end
module tb_top;
  timeunit 1ns;
  timeprecision 100ps;
  import asr_pkg::*;
  localparam int REC = 20;  // short recovery
  // controller and pins
  logic              sys_clk, rst_n, clk_en, req_valid, req_write;
  logic              req_ready, rd_valid, pwr_down_req, pwr_good, pwr_off_ok;
  logic [ADDR_W-1:0] req_addr, mem_addr;
  logic [DATA_W-1:0] req_wdata, rd_data, dq_in, dq_out;
  logic              select_low_primary_n, select_high_secondary;
  logic              store_n, out_gate_n, dq_oe_n, rest;
  logic [1:0]        fault;
  int                fails = 0, checks = 0, cycles = 0;
  // all pins at rest
  assign rest = select_low_primary_n && !select_high_secondary && store_n
                && out_gate_n && dq_oe_n;
  asr_ctrl #(.REC_CYCLES(REC)) i_asr_ctrl (.sys_clk, .rst_n, .clk_en, .req_valid,
    .req_write, .req_addr, .req_wdata, .req_ready, .rd_valid, .rd_data,
    .pwr_down_req, .pwr_good, .pwr_off_ok, .mem_addr, .select_low_primary_n,
    .select_high_secondary, .store_n, .out_gate_n, .dq_in, .dq_out, .dq_oe_n);
  asr_sram_model i_asr_sram_model (.mem_addr, .select_low_primary_n,
    .select_high_secondary, .store_n, .out_gate_n, .dq_out, .dq_oe_n, .dq_in,
    .fault);
  // clock
  initial
  begin
    sys_clk = 1'b0;
    forever #12.5 sys_clk = ~sys_clk;
  end
  // verdict
  task automatic conclude();
    $display("checks %0d fails %0d", checks, fails);
    if (fails == 0 && checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  // hang guard
  always @(posedge sys_clk)
  begin
    cycles++;
    if (cycles == 6000)
    begin
      fails++;
      conclude();
    end
  end
  task automatic cyc(input int n);
    repeat (n) @(negedge sys_clk);
  endtask
  // wait for ready, pins must rest meanwhile
  task automatic wait_idle(output int k);
    k = 0;
    while (req_ready !== 1'b1 && k < 100)
    begin
      `CHK(rest, 1'b1)
      cyc(1);
      k++;
    end
    `CHK(req_ready, 1'b1)
  endtask
  // one request; stall freezes three enabled cycles
  task automatic access(input logic wr, input logic [ADDR_W-1:0] a,
    input logic [DATA_W-1:0] d, input int stall,
    output logic [DATA_W-1:0] q, output int lat, output int low);
    req_valid = 1'b1;
    req_write = wr;
    req_addr  = a;
    req_wdata = d;
    cyc(1);
    req_valid = 1'b0;
    lat = 0;
    low = 0;
    while (lat < 40 && (wr ? req_ready : rd_valid) !== 1'b1)
    begin
      clk_en = !(stall > 0 && lat >= 2 && lat < 5);
      low += (store_n === 1'b0);
      if (wr) `CHK(out_gate_n, 1'b1)
      cyc(1);
      lat++;
    end
    clk_en = 1'b1;
    q = rd_data;
  endtask
  // reset and recovery
  task automatic t_reset();
    int k;
    rst_n = 1'b0;
    cyc(8);
    `CHK(rest && !req_ready, 1'b1)
    rst_n = 1'b1;
    wait_idle(k);
    `CHK(k >= REC, 1'b1)
  endtask
  // edge addresses, overwrite, read back
  task automatic t_rw();
    logic [ADDR_W-1:0] a [3] = '{17'h0_0000, 17'h1_ffff, 17'h0_aaaa};
    logic [DATA_W-1:0] d [3] = '{8'ha5, 8'h3c, 8'hff};
    logic [DATA_W-1:0] q;
    int lat, low;
    for (int i = 0; i < 3; i++)
    begin
      access(1'b1, a[i], ~d[i], 0, q, lat, low);
      access(1'b1, a[i], d[i], 0, q, lat, low);
      `CHK(lat, 8)
      `CHK(low, 5)
    end
    for (int i = 0; i < 3; i++)
    begin
      access(1'b0, a[i], DATA_ZERO, i, q, lat, low);
      `CHK(q, d[i])
      `CHK(lat, (i > 0) ? 12 : 9)
    end
  endtask
  // power down, refused write in recovery, data kept
  task automatic t_power();
    logic [DATA_W-1:0] q;
    int k, lat, low;
    pwr_down_req = 1'b1;
    cyc(2);
    `CHK(pwr_off_ok, 1'b1)
    `CHK(rest && !req_ready, 1'b1)
    pwr_good = 1'b0;
    cyc(4);
    pwr_down_req = 1'b0;
    pwr_good = 1'b1;
    {req_valid, req_write, req_addr, req_wdata} = {2'h3, 17'h1_ffff, DATA_ZERO};
    cyc(5);
    `CHK(pwr_off_ok, 1'b0)
    req_valid = 1'b0;
    wait_idle(k);
    `CHK(k + 5 >= REC, 1'b1)
    access(1'b0, 17'h1_ffff, DATA_ZERO, 0, q, lat, low);
    `CHK(lat, 9)
    `CHK(q, 8'h3c)
  endtask
  // main sequence
  initial
  begin
    {rst_n, clk_en, req_valid, req_write, pwr_down_req, pwr_good} = 6'h11;
    req_addr  = ADDR_ZERO;
    req_wdata = DATA_ZERO;
    t_reset();
    t_rw();
    t_power();
    `CHK(fault, 2'h0)
    conclude();
  end
endmodule
